// >>> dcp_pkg.sv
// Constants shared by the decoder control port files.
// Assumes one 20 MHz core clock and an asynchronous active-high reset.
package dcp_pkg;

  // ****************************************
  // Register space
  // ****************************************
  localparam int          DCP_ADDR_W   = 6;                 // 64 control registers
  localparam int          DCP_DATA_W   = 8;                 // Byte wide host bus
  localparam int          DCP_NUM_REGS = 64;
  localparam logic [5:0]  DCP_PTR_LAST = 6'h3F;             // Pointer stops here
  localparam logic [5:0]  DCP_PTR_RST  = 6'h00;             // Pointer after reset

  // ****************************************
  // Parallel port decode
  // ****************************************
  localparam logic        DCP_SEL_PTR  = 1'b0;              // Address line low: pointer
  localparam logic        DCP_SEL_DATA = 1'b1;              // Address line high: data

  // ****************************************
  // Serial port
  // ****************************************
  localparam logic [3:0]  DCP_SER_BASE = 4'h4;              // Arbitrary upper address bits
  localparam logic [3:0]  DCP_BITS_BYTE = 4'h8;             // Bits in one serial byte
  localparam int          DCP_SYNC_STAGES = 3;              // Pin synchroniser depth

  // Serial slave states
  typedef enum logic [3:0] {
    DCP_S_IDLE,
    DCP_S_ADDR,
    DCP_S_ADDR_ACK,
    DCP_S_PTR,
    DCP_S_PTR_ACK,
    DCP_S_WDATA,
    DCP_S_WDATA_ACK,
    DCP_S_RDATA,
    DCP_S_RDATA_ACK
  } dcp_ser_state_type;

endpackage

// >>> dcp_sync.sv
// Pin synchroniser with agreement filter, one instance per pin.
// Assumes the pin is asynchronous to core_clk_in; output settles after agreement.
`timescale 1ns/1ps
module dcp_sync #(
  parameter logic RST_VAL = 1'b1                            // Idle level of the pin
) (
  input  wire logic core_clk_in,
  input  wire logic reset_in,
  input  wire logic pin_in,
  output logic      level_out
);
  import dcp_pkg::*;

  // ****************************************
  // Three stage chain
  // ****************************************
  logic [DCP_SYNC_STAGES-1:0] chain_q;                      // [0] is the metastable stage

  // Shift pin through the chain
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      chain_q <= {DCP_SYNC_STAGES{RST_VAL}};
    end else begin
      chain_q <= {chain_q[DCP_SYNC_STAGES-2:0], pin_in};
    end
  end

  // Accept a change only once stages two and three agree
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      level_out <= RST_VAL;
    end else if (chain_q[1] == chain_q[2]) begin
      level_out <= chain_q[2];
    end
  end

endmodule

// >>> dcp_top.sv
// Decoder control port: parallel and serial host access to 64 control registers.
// Assumes asynchronous host pins, a 20 MHz core clock and a separate core read port.
`timescale 1ns/1ps

// What this block does
// - Select pin picks parallel or serial port
// - Parallel port twelve pins, serial five pins
// - One address line: pointer or data register
// - Pointer auto-increments, sticks at 3Fh
// - Serial port reaches the same registers
// - Serial device address from three pins
// - Reset idles state machines, enters power-down
// - Register contents survive power-down
module dcp_top (
  input  wire logic                          core_clk_in,
  input  wire logic                          reset_in,
  // Port select, low selects serial
  input  wire logic                          port_select_n_in,
  // Parallel port: 8 data + address + chip select + read + write = 12 pins
  input  wire logic [dcp_pkg::DCP_DATA_W-1:0] host_data_bus_in,
  output logic      [dcp_pkg::DCP_DATA_W-1:0] host_data_bus_out,
  output logic                               host_data_bus_oe_out,
  input  wire logic                          host_addr_in,
  input  wire logic                          host_cs_n_in,
  input  wire logic                          host_rd_n_in,
  input  wire logic                          host_wr_n_in,
  // Serial port: clock, data, three address pins = 5 pins
  input  wire logic                          ser_clk_in,
  input  wire logic                          ser_data_in,
  output logic                               ser_data_out,
  output logic                               ser_data_oe_out,
  input  wire logic [2:0]                    serial_device_addr_pins_in,
  // Decoder core side
  input  wire logic [dcp_pkg::DCP_ADDR_W-1:0] core_addr_in,
  output logic      [dcp_pkg::DCP_DATA_W-1:0] core_data_out,
  output logic                               power_down_out
);
  import dcp_pkg::*;

  // ****************************************
  // Synchronised pins
  // ****************************************
  logic                  sel_n_s;                           // Port select
  logic                  addr_s;                            // Parallel address line
  logic                  cs_n_s;                            // Chip select
  logic                  rd_n_s;                            // Read strobe
  logic                  wr_n_s;                            // Write strobe
  logic                  scl_s;                             // Serial clock
  logic                  sda_s;                             // Serial data
  logic [DCP_DATA_W-1:0] bus_s;                             // Parallel data
  logic [2:0]            sa_s;                              // Serial address pins
  logic [17:0]           pins_raw;                          // Packed raw pins
  logic [17:0]           pins_sync;                         // Packed clean pins

  assign pins_raw = {port_select_n_in, host_addr_in, host_cs_n_in, host_rd_n_in, host_wr_n_in,
                     ser_clk_in, ser_data_in, host_data_bus_in, serial_device_addr_pins_in};

  // One synchroniser per pin, idle high; address pins settle long before a first start
  for (genvar g = 0; g < 18; g++) begin : g_sync
    dcp_sync #(.RST_VAL(1'b1)) u_sync (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .pin_in      (pins_raw[g]),
      .level_out   (pins_sync[g])
    );
  end

  assign {sel_n_s, addr_s, cs_n_s, rd_n_s, wr_n_s, scl_s, sda_s, bus_s, sa_s} = pins_sync;

  // ****************************************
  // Mode and edges
  // ****************************************
  logic par_mode;                                           // Parallel port active
  logic wr_n_q;                                             // Last write strobe
  logic rd_n_q;                                             // Last read strobe
  logic scl_q;                                              // Last serial clock
  logic sda_q;                                              // Last serial data
  logic par_wr_end;                                         // Write strobe released
  logic par_rd_end;                                         // Read strobe released
  logic scl_rise, scl_fall, ser_start, ser_stop;            // Serial bus events

  assign par_mode   = sel_n_s;
  assign par_wr_end = par_mode && !cs_n_s && !wr_n_q && wr_n_s;
  assign par_rd_end = par_mode && !cs_n_s && !rd_n_q && rd_n_s;
  assign scl_rise   = !par_mode && !scl_q && scl_s;
  assign scl_fall   = !par_mode && scl_q && !scl_s;
  // Data may only change with clock high for start and stop
  assign ser_start  = !par_mode && scl_q && scl_s && sda_q && !sda_s;
  assign ser_stop   = !par_mode && scl_q && scl_s && !sda_q && sda_s;

  // Edge history of the cleaned strobes
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
    end else begin
      wr_n_q <= wr_n_s;
      rd_n_q <= rd_n_s;
      scl_q  <= scl_s;
      sda_q  <= sda_s;
    end
  end

  // ****************************************
  // Register storage and pointer
  // ****************************************
  logic [DCP_DATA_W-1:0] regs_q [DCP_NUM_REGS];             // No reset: kept through power-down
  logic [DCP_ADDR_W-1:0] ptr_q;                             // Shared address pointer
  logic                  reg_we;                            // Write into regs_q[ptr_q]
  logic [DCP_DATA_W-1:0] reg_wdata;
  logic                  ptr_load;                          // Load pointer
  logic [DCP_ADDR_W-1:0] ptr_ldval;
  logic                  ptr_step;                          // Data access done
  dcp_ser_state_type     ser_state_q;
  logic [DCP_DATA_W-1:0] ser_shift_q;
  logic [3:0]            ser_cnt_q;

  // Saturating increment, stops at the last register
  function automatic logic [DCP_ADDR_W-1:0] ptr_next(input logic [DCP_ADDR_W-1:0] p);
    ptr_next = (p == DCP_PTR_LAST) ? p : p + 6'h01;
  endfunction

  // Write sources: parallel data write or completed serial data byte
  always_comb begin
    reg_we    = 1'b0;
    reg_wdata = bus_s;
    ptr_load  = 1'b0;
    ptr_ldval = bus_s[DCP_ADDR_W-1:0];
    ptr_step  = 1'b0;
    if (par_mode) begin
      if (par_wr_end && addr_s == DCP_SEL_PTR) begin
        ptr_load = 1'b1;
      end else if (par_wr_end) begin
        reg_we   = 1'b1;
        ptr_step = 1'b1;
      end else if (par_rd_end && addr_s == DCP_SEL_DATA) begin
        ptr_step = 1'b1;
      end
    end else if (scl_fall) begin
      if (ser_state_q == DCP_S_PTR && ser_cnt_q == DCP_BITS_BYTE) begin
        ptr_load  = 1'b1;
        ptr_ldval = ser_shift_q[DCP_ADDR_W-1:0];
      end else if (ser_state_q == DCP_S_WDATA && ser_cnt_q == DCP_BITS_BYTE) begin
        reg_we    = 1'b1;
        reg_wdata = ser_shift_q;
        ptr_step  = 1'b1;
      end else if (ser_state_q == DCP_S_RDATA && ser_cnt_q == 4'h7) begin
        ptr_step  = 1'b1;                                   // Every byte read, nack too
      end
    end
  end

  // Storage has no reset so contents outlive power-down
  always_ff @(posedge core_clk_in) begin
    if (reg_we && !reset_in) begin
      regs_q[ptr_q] <= reg_wdata;
    end
  end

  // Pointer: load replaces, data access steps
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ptr_q <= DCP_PTR_RST;
    end else if (ptr_load) begin
      ptr_q <= ptr_ldval;
    end else if (ptr_step) begin
      ptr_q <= ptr_next(ptr_q);
    end
  end

  // ****************************************
  // Serial slave
  // ****************************************
  logic [6:0] ser_dev_addr;                                 // Own serial address
  assign ser_dev_addr = {DCP_SER_BASE, sa_s};

  // Byte engine, started and stopped by bus conditions
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ser_state_q <= DCP_S_IDLE;
      ser_shift_q <= 8'h00;
      ser_cnt_q   <= 4'h0;
    end else if (par_mode || ser_stop) begin
      ser_state_q <= DCP_S_IDLE;
    end else if (ser_start) begin
      ser_state_q <= DCP_S_ADDR;
      ser_cnt_q   <= 4'h0;
    end else if (scl_rise) begin
      unique case (ser_state_q)
        DCP_S_ADDR, DCP_S_PTR, DCP_S_WDATA: begin
          ser_shift_q <= {ser_shift_q[6:0], sda_s};
          ser_cnt_q   <= ser_cnt_q + 4'h1;
        end
        DCP_S_RDATA_ACK: begin
          // Master nack ends the read burst
          if (sda_s) begin
            ser_state_q <= DCP_S_IDLE;
          end
        end
        default: begin
          ser_cnt_q <= ser_cnt_q;
        end
      endcase
    end else if (scl_fall) begin
      unique case (ser_state_q)
        DCP_S_ADDR: begin
          if (ser_cnt_q == DCP_BITS_BYTE) begin
            ser_state_q <= (ser_shift_q[7:1] == ser_dev_addr) ? DCP_S_ADDR_ACK : DCP_S_IDLE;
          end
        end
        DCP_S_ADDR_ACK: begin
          ser_cnt_q <= 4'h0;
          if (ser_shift_q[0]) begin
            ser_state_q <= DCP_S_RDATA;
            ser_shift_q <= regs_q[ptr_q];
          end else begin
            ser_state_q <= DCP_S_PTR;
          end
        end
        DCP_S_PTR: begin
          if (ser_cnt_q == DCP_BITS_BYTE) begin
            ser_state_q <= DCP_S_PTR_ACK;
          end
        end
        DCP_S_WDATA: begin
          if (ser_cnt_q == DCP_BITS_BYTE) begin
            ser_state_q <= DCP_S_WDATA_ACK;
          end
        end
        DCP_S_PTR_ACK, DCP_S_WDATA_ACK: begin
          ser_state_q <= DCP_S_WDATA;
          ser_cnt_q   <= 4'h0;
        end
        DCP_S_RDATA: begin
          ser_shift_q <= {ser_shift_q[6:0], 1'b0};
          ser_cnt_q   <= ser_cnt_q + 4'h1;
          if (ser_cnt_q == 4'h7) begin
            ser_state_q <= DCP_S_RDATA_ACK;
          end
        end
        DCP_S_RDATA_ACK: begin
          // Pointer already stepped; fetch the next register
          ser_state_q <= DCP_S_RDATA;
          ser_shift_q <= regs_q[ptr_q];
          ser_cnt_q   <= 4'h0;
        end
        default: begin
          ser_state_q <= DCP_S_IDLE;
        end
      endcase
    end
  end

  // Open drain: drive only zeros, ack slots and read zeros
  always_comb begin
    ser_data_out    = 1'b0;
    ser_data_oe_out = (ser_state_q == DCP_S_ADDR_ACK) || (ser_state_q == DCP_S_PTR_ACK) ||
                      (ser_state_q == DCP_S_WDATA_ACK) ||
                      (ser_state_q == DCP_S_RDATA && !ser_shift_q[7]);
  end

  // ****************************************
  // Parallel read data and core port
  // ****************************************
  // Read data refreshed every cycle from the decoded target
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      host_data_bus_out <= 8'h00;
    end else if (addr_s == DCP_SEL_PTR) begin
      host_data_bus_out <= {2'b00, ptr_q};
    end else begin
      host_data_bus_out <= regs_q[ptr_q];
    end
  end

  // Drive only while selected and reading in parallel mode
  assign host_data_bus_oe_out = par_mode && !cs_n_s && !rd_n_s;

  // Core read of any register, independent of host traffic
  always_ff @(posedge core_clk_in) begin
    core_data_out <= regs_q[core_addr_in];
  end

  // Power-down follows reset; registers untouched
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      power_down_out <= 1'b1;
    end else begin
      power_down_out <= 1'b0;
    end
  end

endmodule

// >>> dcp_props.sv
// Checker for the decoder control port pins.
// Assumes it is bound to every dcp_top instance and sees only its ports.
`timescale 1ns/1ps
module dcp_props (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic port_select_n_in,
  input wire logic ser_clk_in,
  input wire logic host_cs_n_in,
  input wire logic host_rd_n_in,
  input wire logic host_data_bus_oe_out,
  input wire logic ser_data_out,
  input wire logic ser_data_oe_out,
  input wire logic power_down_out
);
  import dcp_pkg::*;
  // First edge may see outputs before the reset branch has run
  logic armed_q = 1'b0;
  always @(posedge core_clk_in) armed_q <= 1'b1;
  // ****************************************
  // Assertions
  // ****************************************
  // Held reset always means power-down; no disable, reset is the cause
  a_pd_in_reset: assert property (@(posedge core_clk_in)
    (armed_q && reset_in) |-> power_down_out)
    else $error("power down low while reset held");
  a_pd_release: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !$past(reset_in) |-> !power_down_out) else $error("power down stuck after reset");
  // Six quiet cycles cover the pin synchroniser latency
  a_serial_no_par: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !port_select_n_in [*6] |-> !host_data_bus_oe_out) else $error("bus driven in serial mode");
  a_par_no_ser: assert property (@(posedge core_clk_in) disable iff (reset_in)
    port_select_n_in [*6] |-> !ser_data_oe_out) else $error("serial data driven in parallel mode");
  a_oe_needs_rd: assert property (@(posedge core_clk_in) disable iff (reset_in)
    host_rd_n_in [*6] |-> !host_data_bus_oe_out) else $error("bus driven without read strobe");
  a_oe_needs_cs: assert property (@(posedge core_clk_in) disable iff (reset_in)
    host_cs_n_in [*6] |-> !host_data_bus_oe_out) else $error("bus driven without chip select");
  a_oe_on_read: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (port_select_n_in && !host_cs_n_in && $fell(host_rd_n_in)) |-> ##[2:6] host_data_bus_oe_out)
    else $error("read did not drive bus");
  // Open drain: the data output may only ever pull low
  a_ser_pull_low: assert property (@(posedge core_clk_in) disable iff (reset_in)
    ser_data_oe_out |-> ser_data_out == 1'b0) else $error("serial data driven high");
  // Ack and read bits may only move while the serial clock is low
  a_oe_clk_low: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $changed(ser_data_oe_out) |-> !ser_clk_in) else $error("serial data moved with clock high");
  // ****************************************
  // Covers
  // ****************************************
  c_par_read: cover property (@(posedge core_clk_in) $rose(host_data_bus_oe_out));
  c_ser_ack: cover property (@(posedge core_clk_in) $rose(ser_data_oe_out));
  c_pd_exit: cover property (@(posedge core_clk_in) $fell(power_down_out));
endmodule
bind dcp_top dcp_props u_props (.core_clk_in, .reset_in, .port_select_n_in, .ser_clk_in, .host_cs_n_in,
  .host_rd_n_in, .host_data_bus_oe_out, .ser_data_out, .ser_data_oe_out, .power_down_out);

// >>> dcp_host_model.sv
// Host processor model: parallel strobes and a two-wire serial master.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module dcp_host_model (
  input  wire logic       clk_in,
  input  wire logic       sda_in,
  input  wire logic [7:0] rdata_in,
  output logic            scl_out,
  output logic            sda_pull_out,
  output logic [7:0]      data_out,
  output logic            addr_out,
  output logic            cs_n_out,
  output logic            rd_n_out,
  output logic            wr_n_out
);
  // Idle: strobes high, serial lines released
  initial begin
    {scl_out, sda_pull_out, data_out, addr_out} = {1'b1, 1'b0, 8'h00, 1'b0};
    {cs_n_out, rd_n_out, wr_n_out} = 3'h7;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // One parallel access; strobes held 8 cycles, gap 7, well above the sync latency
  task automatic pacc(input logic a, input logic wr, input logic [7:0] d, output logic [7:0] q);
    addr_out <= a;
    cs_n_out <= 1'b0;
    data_out <= d;
    wt(1);
    wr_n_out <= !wr;
    rd_n_out <= wr;
    wt(8);
    q = rdata_in;
    {wr_n_out, rd_n_out} <= 2'h3;
    wt(1);
    cs_n_out <= 1'b1;
    data_out <= ~d; // Released bus shows no stale value
    wt(6);
  endtask
  // One serial clock pulse, 10-cycle half periods; sampled mid-high
  task automatic sbit(output logic s);
    wt(10);
    scl_out <= 1'b1;
    wt(5);
    s = sda_in;
    wt(5);
    scl_out <= 1'b0;
    wt(2); // Data hold after clock falls
  endtask
  // Byte MSB first, then the ack slot with the line released
  task automatic sbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_pull_out <= !b[i];
      sbit(s);
    end
    sda_pull_out <= 1'b0;
    sbit(ack);
  endtask
  // Read byte MSB first with the line released, then master ack (0) or nack (1)
  task automatic srbyte(input logic nack, output logic [7:0] q);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_pull_out <= 1'b0;
      sbit(s);
      q[i] = s;
    end
    sda_pull_out <= !nack;
    sbit(s);
  endtask
  task automatic sstart();
    sda_pull_out <= 1'b1; // Data falls while clock high
    wt(10);
    scl_out <= 1'b0;
    wt(2);
  endtask
  task automatic sstop();
    sda_pull_out <= 1'b1;
    wt(10);
    scl_out <= 1'b1;
    wt(10);
    sda_pull_out <= 1'b0; // Data rises while clock high, then clocks stand still
    wt(10);
  endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the decoder control port.
// Assumes dcp_top with the host model on its pins; no parameters to shorten.
`timescale 1ns/1ps
module testbench;
  import dcp_pkg::*;
  logic       core_clk_in = 1'b0, reset_in = 1'b1, port_select_n_in = 1'b1;
  logic [2:0] sa_q = 3'h5;                      // Serial address pins
  logic [5:0] core_addr_q = 6'h00;
  logic [7:0] hd, rd, cd;                       // Host data, read data, core data
  logic       ha, cs_n, rd_n, wr_n, oe, scl, m_pull, s_out, s_oe, pd, sda, ack;
  int         n_fail = 0, tests_run = 0;
  // Pull-up on the shared serial data line
  assign sda = !(m_pull || (s_oe && !s_out));
  always #25 core_clk_in = !core_clk_in;
  dcp_top dut (.core_clk_in, .reset_in, .port_select_n_in, .host_data_bus_in(hd),
    .host_data_bus_out(rd), .host_data_bus_oe_out(oe), .host_addr_in(ha),
    .host_cs_n_in(cs_n), .host_rd_n_in(rd_n), .host_wr_n_in(wr_n), .ser_clk_in(scl),
    .ser_data_in(sda), .ser_data_out(s_out), .ser_data_oe_out(s_oe),
    .serial_device_addr_pins_in(sa_q), .core_addr_in(core_addr_q), .core_data_out(cd),
    .power_down_out(pd));
  dcp_host_model host (.clk_in(core_clk_in), .sda_in(sda), .rdata_in(rd), .scl_out(scl),
    .sda_pull_out(m_pull), .data_out(hd), .addr_out(ha), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n));
  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pw(input logic a, input logic [7:0] d);
    logic [7:0] q;
    host.pacc(a, 1'b1, d, q);
  endtask
  task automatic pr(input logic a, output logic [7:0] q);
    host.pacc(a, 1'b0, 8'h00, q);
  endtask
  // Core read port, one cycle latency plus margin
  task automatic core_rd(input logic [5:0] a, output logic [7:0] q);
    core_addr_q <= a;
    host.wt(3);
    q = cd;
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // Pointer stepping, saturation and pointer reads
  task automatic t_parallel();
    logic [7:0] q;
    pw(1'b0, 8'h3E);                           // Pointer first
    pw(1'b1, 8'hA1);
    pw(1'b1, 8'hB2);
    pw(1'b1, 8'hC3);                           // Pointer already at the last address
    pr(1'b0, q); check(q, 8'h3F);
    core_rd(6'h3E, q); check(q, 8'hA1);
    core_rd(6'h3F, q); check(q, 8'hC3);
    pw(1'b0, 8'h10);
    pw(1'b1, 8'h55);
    pw(1'b0, 8'h10);                           // Reload must not step
    pr(1'b1, q); check(q, 8'h55);
    pr(1'b0, q); check(q, 8'h11);
    pr(1'b0, q); check(q, 8'h11);
    $display("t_parallel done");
  endtask
  // Serial write, address pins moved, refusals, pointer-only write, burst read,
  // parallel ignored in serial mode
  task automatic t_serial();
    logic [7:0] q;
    port_select_n_in <= 1'b0;
    host.wt(8);
    host.sstart();
    host.sbyte({DCP_SER_BASE, sa_q, 1'b0}, ack); check(ack, 8'h00);
    host.sbyte(8'h20, ack); check(ack, 8'h00);
    host.sbyte(8'h5A, ack); check(ack, 8'h00);
    host.sbyte(8'hA5, ack); check(ack, 8'h00);
    host.sstop();
    host.sstart();
    host.sbyte({DCP_SER_BASE, 3'h2, 1'b0}, ack); check(ack, 8'h01);
    host.sstop();
    sa_q <= 3'h2;                              // Move the device to a new address
    host.wt(8);
    host.sstart();
    host.sbyte({DCP_SER_BASE, 3'h5, 1'b1}, ack); check(ack, 8'h01);
    host.sstop();
    host.sstart();
    host.sbyte({DCP_SER_BASE, 3'h2, 1'b0}, ack); check(ack, 8'h00);
    host.sbyte(8'h20, ack); check(ack, 8'h00);
    host.sstop();
    host.sstart();
    host.sbyte({DCP_SER_BASE, 3'h2, 1'b1}, ack); check(ack, 8'h00);
    host.srbyte(1'b0, q); check(q, 8'h5A);
    host.srbyte(1'b1, q); check(q, 8'hA5);
    host.sstop();
    pw(1'b0, 8'h05);                           // Must be ignored in serial mode
    port_select_n_in <= 1'b1;
    host.wt(8);
    pr(1'b0, q); check(q, 8'h22);
    core_rd(6'h20, q); check(q, 8'h5A);
    core_rd(6'h21, q); check(q, 8'hA5);
    $display("t_serial done");
  endtask
  // Mid-run reset: power-down, pointer cleared, registers kept
  task automatic t_reset();
    logic [7:0] q;
    reset_in <= 1'b1;
    host.wt(3);
    check(pd, 8'h01);
    reset_in <= 1'b0;
    host.wt(8);
    check(pd, 8'h00);
    pr(1'b0, q); check(q, 8'h00);
    core_rd(6'h3E, q); check(q, 8'hA1);
    $display("t_reset done");
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    host.wt(12);
    reset_in <= 1'b0;
    host.wt(8);
    t_parallel();
    t_serial();
    t_reset();
    test_done();
  end
  initial begin
    host.wt(20000);
    n_fail++;
    test_done();
  end
endmodule
